// ===== rtl/ars_sequencer.v
// Contract
// R1: mode 0 default: no automatic acknowledge, no automatic switch-on.
// R2: modes 1 and 26 acknowledge faults always.
// R3: modes 4 and 6 acknowledge faults only while run command high.
// R4: modes 14 and 16 never acknowledge automatically.
// R5: mode 1 never switches the motor on automatically.
// R6: modes 4,6,14,16,26 switch on only while run command high.
// R7: undervoltage fault or supply-loss restart count as power failure.
// R8: success needs flying restart done, magnetized, then 1 s without fault.
// R9: attempt counter decrements after each automatic acknowledge.
// R10: limit n allows n+1 attempts, then restart-failed fault.
// R11: counter below zero raises restart-failed and stops attempts.
// R12: reload counter on reset-time expiry, withdraw-and-ack, or setting change.
// R13: attempt limit defaults to 3, effective in modes 4,6,14,16,26.
// R14: wait programmable delay, default 1.0 s, before each attempt.
// R15: wait delay only applies in modes 4, 6 and 26.
// R16: monitoring timer from fault; expiry without success raises restart-failed.
// R17: mode above 1 switches on automatically after power failure.
// R18: fieldbus controller should acknowledge and switch on explicitly itself.
// R19: monitoring time defaults to 60 s.
// R20: monitoring time zero disables monitoring.
// R21: inputs sampled synchronously; all times from a common tick.
`timescale 1ns/100ps
`include "ars_consts.vh"
module ars_sequencer #(
  parameter TICK_DIV = `ARS_TICK_CYC,
  parameter [7:0] LIMIT_DEF = `ARS_LIMIT_DEF,
  parameter [31:0] WAIT_DEF = `ARS_WAIT_MS_DEF,
  parameter [31:0] MON_DEF = `ARS_MON_MS_DEF,
  parameter [31:0] SUCCESS_TICKS = `ARS_SUCCESS_MS
) (
  input wire mclk_i, // 100 MHz clock
  input wire rst_n_i, // sync reset, active low
  input wire [7:0] restart_mode_sel_i, // restart mode
  input wire [7:0] start_attempt_limit_i, // attempt limit n
  input wire [31:0] attempt_wait_time_i, // wait in ms ticks
  input wire [31:0] restart_monitor_time_i, // monitor time in ms, 0 off
  input wire [31:0] counter_reset_time_i, // counter reset time in ms, 0 off
  input wire use_defaults_i, // 1: use built-in defaults for settings
  input wire run_command_i, // run command pin
  input wire fault_i, // fault pending level
  input wire dc_link_undervolt_fault_i, // undervoltage fault level
  input wire power_up_i, // pulse: device came back after supply loss
  input wire flying_restart_done_i, // flying restart completed
  input wire magnetizing_done_flag_i, // motor magnetized
  input wire ext_ack_i, // external fault acknowledge pulse
  output reg auto_ack_o, // one-cycle automatic acknowledge
  output reg auto_on_o, // automatic switch-on level
  output reg restart_failed_fault_o, // restart failed fault level
  output reg power_fail_o, // power failure seen since last successful restart
  output reg [8:0] attempts_left_o // signed attempt counter
);
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ACK = 6'h02;
  localparam [5:0] S_WAIT = 6'h04;
  localparam [5:0] S_START = 6'h08;
  localparam [5:0] S_PROVE = 6'h10;
  localparam [5:0] S_FAIL = 6'h20;

  // two flops on every pin input before use
  reg [6:0] s1_r, s2_r;
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s1_r <= 7'h00;
      s2_r <= 7'h00;
    end else begin
      s1_r <= {ext_ack_i, power_up_i, magnetizing_done_flag_i, flying_restart_done_i,
               dc_link_undervolt_fault_i, fault_i, run_command_i}; // R21
      s2_r <= s1_r;
    end
  end
  wire run_s = s2_r[0];
  wire flt_s = s2_r[1];
  wire uv_s = s2_r[2];
  wire fly_s = s2_r[3];
  wire mag_s = s2_r[4];
  wire pwr_s = s2_r[5];
  wire ack_s = s2_r[6];
  reg flt_d_r, pwr_d_r, ack_d_r;
  wire any_flt = flt_s | uv_s;
  wire flt_rise = any_flt & ~flt_d_r;
  wire pwr_rise = pwr_s & ~pwr_d_r;
  wire ack_rise = ack_s & ~ack_d_r;

  wire [7:0] mode = restart_mode_sel_i;
  wire [7:0] lim = use_defaults_i ? LIMIT_DEF : start_attempt_limit_i; // R13
  wire [31:0] wait_t = use_defaults_i ? WAIT_DEF : attempt_wait_time_i; // R14
  wire [31:0] mon_t = use_defaults_i ? MON_DEF : restart_monitor_time_i; // R19
  wire [31:0] rst_t = use_defaults_i ? `ARS_CNTRST_MS_DEF : counter_reset_time_i;

  wire m_ack1 = (mode == `ARS_MODE_ACK_ONLY);
  wire m_a26 = (mode == `ARS_MODE_ACK_ON);
  wire m_pf = (mode == `ARS_MODE_PF) | (mode == `ARS_MODE_FLT);
  wire m_man = (mode == `ARS_MODE_PF_MAN) | (mode == `ARS_MODE_FLT_MAN);
  wire m_restart = m_pf | m_man | m_a26; // R13
  wire ack_ok = m_ack1 | m_a26 | (m_pf & run_s); // R2 R3 R4
  wire on_ok = m_restart & run_s; // R5 R6
  wire use_wait = m_pf | m_a26; // R15

  reg [5:0] st_r, st_nxt;
  reg [8:0] cnt_nxt;
  reg [7:0] mode_d_r, lim_d_r;
  reg succ_once_r;
  // one acknowledge per stay in ACK, so a fault held a few cycles costs one attempt
  reg acked_r;
  wire ack_take = (st_r == S_ACK) & any_flt & (ack_ok | (m_man & ack_rise)) & ~restart_failed_fault_o & ~acked_r;
  wire tick;
  wire wait_done, prove_done, mon_done, crst_done;
  reg wait_go, prove_go, mon_go, mon_stop, crst_go;

  ars_tick #(.DIV(TICK_DIV)) u_tick (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );
  ars_timer u_wait (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .tick_i(tick), .start_i(wait_go),
    .stop_i(st_r == S_IDLE), .len_i(wait_t), .run_o(), .done_o(wait_done)
  );
  ars_timer u_prove (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .tick_i(tick), .start_i(prove_go),
    .stop_i(flt_rise), .len_i(SUCCESS_TICKS), .run_o(), .done_o(prove_done)
  );
  ars_timer u_mon (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .tick_i(tick), .start_i(mon_go),
    .stop_i(mon_stop), .len_i(mon_t), .run_o(), .done_o(mon_done)
  );
  ars_timer u_crst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .tick_i(tick), .start_i(crst_go),
    .stop_i(flt_rise), .len_i(rst_t), .run_o(), .done_o(crst_done)
  );

  wire setting_chg = (mode != mode_d_r) | (lim != lim_d_r);
  wire [8:0] reload = {1'b0, lim};
  wire [8:0] cnt_dec = attempts_left_o - 9'h001;

  always @* begin
    st_nxt = st_r;
    cnt_nxt = attempts_left_o;
    wait_go = 1'b0;
    prove_go = 1'b0;
    mon_go = 1'b0;
    mon_stop = 1'b0;
    crst_go = 1'b0;
    case (st_r)
      S_IDLE: begin
        if ((flt_rise | pwr_rise) & (m_ack1 | m_restart)) begin
          st_nxt = S_ACK;
          mon_go = m_restart & (mon_t != 32'h0); // R16 R20
        end
      end
      S_ACK: begin
        if (!any_flt) begin
          // fault already cleared by the outside or by our own pulse
          if (m_ack1) begin
            st_nxt = S_IDLE; // R5
          end else if (on_ok) begin
            st_nxt = use_wait ? S_WAIT : S_START; // R15
            wait_go = use_wait; // R14
          end
        end else if (ack_take) begin // R4
          cnt_nxt = cnt_dec; // R9
        end
      end
      S_WAIT: begin
        if (!on_ok) begin
          st_nxt = S_ACK;
        end else if (wait_done) begin
          st_nxt = S_START;
        end
      end
      S_START: begin
        if (!on_ok) begin
          st_nxt = S_ACK;
        end else if (fly_s & mag_s) begin
          st_nxt = S_PROVE; // R8
          prove_go = 1'b1;
        end else if (any_flt) begin
          st_nxt = S_ACK;
        end
      end
      S_PROVE: begin
        if (any_flt) begin
          st_nxt = S_ACK;
        end else if (prove_done) begin
          st_nxt = S_IDLE; // R8
          mon_stop = 1'b1;
          crst_go = rst_t != 32'h0;
        end
      end
      S_FAIL: begin
        mon_stop = 1'b1;
        if (!run_s & ack_rise) begin
          st_nxt = S_IDLE;
          cnt_nxt = reload; // R12
        end
      end
      default: st_nxt = S_IDLE;
    endcase
    if (st_r != S_FAIL && st_r != S_IDLE && m_restart) begin
      // done pulses as the timer stops, so it is used alone
      if (cnt_nxt[8] | mon_done) begin
        st_nxt = S_FAIL; // R10 R11 R16
      end
    end
    if (crst_done) begin
      cnt_nxt = reload; // R12
    end
    if (setting_chg) begin
      cnt_nxt = reload; // R12
      if (!m_ack1 && !m_restart) begin
        st_nxt = S_IDLE; // R1
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_r <= S_IDLE;
      attempts_left_o <= {1'b0, `ARS_LIMIT_DEF};
      mode_d_r <= `ARS_MODE_OFF;
      lim_d_r <= `ARS_LIMIT_DEF;
      flt_d_r <= 1'b0;
      pwr_d_r <= 1'b0;
      ack_d_r <= 1'b0;
      succ_once_r <= 1'b0;
      acked_r <= 1'b0;
      auto_ack_o <= 1'b0;
      auto_on_o <= 1'b0;
      restart_failed_fault_o <= 1'b0;
      power_fail_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      attempts_left_o <= cnt_nxt;
      mode_d_r <= mode;
      lim_d_r <= lim;
      flt_d_r <= any_flt;
      pwr_d_r <= pwr_s;
      ack_d_r <= ack_s;
      succ_once_r <= (st_r == S_PROVE) & prove_done;
      acked_r <= (st_nxt == S_ACK) & (acked_r | ack_take);
      // auto acknowledge pulses on the same cycle the counter is decremented
      auto_ack_o <= ack_take & ack_ok & (st_nxt == S_ACK); // R2 R3
      // switch-on held through wait-free start and proving; withdrawn on failure
      auto_on_o <= on_ok & ((st_nxt == S_START) | (st_nxt == S_PROVE)); // R6 R17
      restart_failed_fault_o <= (st_nxt == S_FAIL); // R10 R11
      if (pwr_rise | (flt_rise & uv_s)) begin
        power_fail_o <= 1'b1; // R7
      end else if (succ_once_r) begin
        power_fail_o <= 1'b0;
      end
    end
  end
endmodule

// ===== rtl/ars_consts.vh
`ifndef ARS_CONSTS_VH
`define ARS_CONSTS_VH
// restart mode codes
`define ARS_MODE_OFF 8'h00
`define ARS_MODE_ACK_ONLY 8'h01
`define ARS_MODE_PF 8'h04
`define ARS_MODE_FLT 8'h06
`define ARS_MODE_PF_MAN 8'h0E
`define ARS_MODE_FLT_MAN 8'h10
`define ARS_MODE_ACK_ON 8'h1A
// defaults
`define ARS_LIMIT_DEF 8'h03
// times in milliseconds
`define ARS_WAIT_MS_DEF 32'd1000
`define ARS_MON_MS_DEF 32'd60000
`define ARS_SUCCESS_MS 32'd1000
`define ARS_CNTRST_MS_DEF 32'd0
// timebase: one tick per millisecond at 100 MHz
`define ARS_CLK_HZ 32'd100000000
`define ARS_TICK_HZ 32'd1000
`define ARS_TICK_CYC (`ARS_CLK_HZ / `ARS_TICK_HZ)
`endif

// ===== rtl/ars_tick.v
`timescale 1ns/100ps
`include "ars_consts.vh"
module ars_tick #(
  parameter DIV = `ARS_TICK_CYC
) (
  input wire mclk_i, // clock
  input wire rst_n_i, // sync reset
  output reg tick_o // one-cycle tick
);
  reg [31:0] cnt_r;
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_r >= DIV - 1) begin
      cnt_r <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ===== rtl/ars_timer.v
`timescale 1ns/100ps
module ars_timer (
  input wire mclk_i, // clock
  input wire rst_n_i, // sync reset
  input wire tick_i, // timebase tick
  input wire start_i, // load and run
  input wire stop_i, // abort
  input wire [31:0] len_i, // length in ticks
  output wire run_o, // counting
  output reg done_o // one-cycle expiry pulse
);
  reg [31:0] cnt_r;
  reg run_r;
  assign run_o = run_r;
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 32'h0;
      run_r <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (stop_i) begin
        run_r <= 1'b0;
      end else if (start_i) begin
        cnt_r <= len_i;
        run_r <= 1'b1;
      end else if (run_r && tick_i) begin
        if (cnt_r <= 32'h1) begin
          run_r <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 32'h1;
        end
      end
    end
  end
endmodule

// ===== bench/ars_chk.sv
`timescale 1ns/100ps
module ars_chk (
  input wire mclk_i, // clock
  input wire rst_n_i, // sync reset
  input wire [7:0] restart_mode_sel_i, // mode
  input wire [7:0] start_attempt_limit_i, // limit n
  input wire run_command_i, // run command
  input wire auto_ack_o, // auto acknowledge
  input wire auto_on_o, // auto switch-on
  input wire restart_failed_fault_o, // restart failed
  input wire [8:0] attempts_left_o // counter
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_values: assert property (!$past(rst_n_i) |-> attempts_left_o == 9'h003 && !auto_on_o)
    else $error("reset state wrong");
  a_off_quiet: assert property (restart_mode_sel_i == 8'h00 && $past(restart_mode_sel_i) == 8'h00
    |-> !auto_ack_o && !auto_on_o)
    else $error("mode off acted");
  a_mode1_no_on: assert property ($rose(auto_on_o) |-> $past(restart_mode_sel_i) != 8'h01)
    else $error("switch-on in ack-only mode");
  a_manual_no_ack: assert property (auto_ack_o |->
    $past(restart_mode_sel_i) != 8'h0E && $past(restart_mode_sel_i) != 8'h10)
    else $error("auto ack in manual mode");
  a_on_needs_run: assert property (!run_command_i [*6] |-> !auto_on_o)
    else $error("switch-on without run command");
  a_ack_decrements: assert property (auto_ack_o && restart_mode_sel_i != 8'h01 && $stable(start_attempt_limit_i)
    && $stable(restart_mode_sel_i) |-> attempts_left_o == $past(attempts_left_o) - 9'h001)
    else $error("counter not decremented");
  a_neg_fails: assert property (attempts_left_o[8] |-> ##[0:4] restart_failed_fault_o)
    else $error("negative counter without fault");
  a_fail_holds: assert property ((restart_failed_fault_o && run_command_i) [*4] |=> restart_failed_fault_o)
    else $error("failed fault cleared with run high");
endmodule
bind ars_sequencer ars_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .restart_mode_sel_i(restart_mode_sel_i),
  .start_attempt_limit_i(start_attempt_limit_i), .run_command_i(run_command_i), .auto_ack_o(auto_ack_o),
  .auto_on_o(auto_on_o), .restart_failed_fault_o(restart_failed_fault_o), .attempts_left_o(attempts_left_o));

// ===== bench/test_auto_restart_sequencer.sv
`timescale 1ns/100ps
module test_auto_restart_sequencer;
  reg mclk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [7:0] mode = 8'h00;
  reg [7:0] limit = 8'h03;
  reg [31:0] mon = 32'h0;
  reg run = 1'b0, flt = 1'b0, uv = 1'b0, pup = 1'b0, fly = 1'b0, mag = 1'b0, eack = 1'b0;
  wire ack, on, fail, pf;
  wire [8:0] left;
  integer mismatches = 0, checked = 0, cyc = 0, n, k;
  // short tick and proof time keep the run small
  ars_sequencer #(.TICK_DIV(10), .SUCCESS_TICKS(32'h5)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .restart_mode_sel_i(mode), .start_attempt_limit_i(limit), .attempt_wait_time_i(32'h8),
    .restart_monitor_time_i(mon), .counter_reset_time_i(32'h0), .use_defaults_i(1'b0),
    .run_command_i(run), .fault_i(flt), .dc_link_undervolt_fault_i(uv), .power_up_i(pup),
    .flying_restart_done_i(fly), .magnetizing_done_flag_i(mag), .ext_ack_i(eack), .auto_ack_o(ack),
    .auto_on_o(on), .restart_failed_fault_o(fail), .power_fail_o(pf), .attempts_left_o(left));
  initial forever #5 mclk_i = ~mclk_i;
  task stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  task step(input integer c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask
  task chk(input string what, input [8:0] exp, input [8:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // sel: 0 ack, 1 on, 2 fail, 3 on released
  task await(input integer sel, input integer lim);
    n = 0;
    while (n < lim && !(sel == 0 ? ack === 1'b1 : sel == 1 ? on === 1'b1 : sel == 2 ? fail === 1'b1 : on === 1'b0)) begin
      step(1);
      n = n + 1;
    end
  endtask
  task pulse_ack;
    eack = 1'b1;
    step(3);
    eack = 1'b0;
    step(5);
  endtask
  task succeed;
    fly = 1'b1;
    mag = 1'b1;
    step(35);
    chk("on during proof", 9'h1, {8'h00, on});
    await(3, 80);
    chk("on after proof", 9'h0, {8'h00, on});
    fly = 1'b0;
    mag = 1'b0;
    step(5);
  endtask
  task t_gate(input [7:0] m, input r, input exp);
    // passing through off returns the sequencer to idle
    mode = 8'h00;
    step(2);
    mode = m;
    run = r;
    step(5);
    flt = 1'b1;
    await(0, 60);
    chk("auto ack", {8'h00, exp}, {8'h00, ack});
    flt = 1'b0;
    step(10);
  endtask
  task t_restart(input [7:0] m, input manual, input long_wait);
    t_gate(m, 1'b1, !manual);
    if (manual) pulse_ack;
    await(1, 200);
    chk("auto on", 9'h1, {8'h00, on});
    chk("wait applied", {8'h00, long_wait}, {8'h00, n >= 40});
    succeed;
  endtask
  initial begin
    step(5);
    rst_n_i = 1'b1;
    step(3);
    chk("reset count", 9'h003, left);
    t_gate(8'h00, 1'b1, 1'b0);
    t_gate(8'h01, 1'b0, 1'b1);
    step(100);
    chk("ack only on", 9'h0, {8'h00, on});
    t_gate(8'h04, 1'b0, 1'b0);
    t_restart(8'h04, 1'b0, 1'b1);
    t_restart(8'h0E, 1'b1, 1'b0);
    mode = 8'h06;
    pup = 1'b1;
    step(3);
    pup = 1'b0;
    await(1, 200);
    chk("power fail on", 9'h1, {8'h00, on});
    chk("power fail flag", 9'h1, {8'h00, pf});
    succeed;
    limit = 8'h01;
    mode = 8'h1A;
    k = 0;
    repeat (4) if (fail !== 1'b1) begin
      flt = 1'b1;
      await(0, 60);
      step(1);
      flt = 1'b0;
      await(1, 200);
      if (on === 1'b1) k = k + 1;
    end
    chk("failed raised", 9'h1, {8'h00, fail});
    chk("attempt bound", 9'h1, {8'h00, k <= 2});
    run = 1'b0;
    pulse_ack;
    chk("failed cleared", 9'h0, {8'h00, fail});
    chk("reload", 9'h001, left);
    mon = 32'h14;
    mode = 8'h10;
    run = 1'b1;
    flt = 1'b1;
    await(2, 400);
    chk("monitor expiry", 9'h1, {8'h00, fail});
    chk("monitor length", 9'h1, {8'h00, n >= 150});
    run = 1'b0;
    flt = 1'b0;
    pulse_ack;
    limit = 8'h05;
    step(5);
    chk("limit change", 9'h005, left);
    stop_test;
  end
endmodule
